// ==== core/baud_gen_pkg.sv ====
/*
  constants shared by the serial port rate generator: register offsets,
  field positions, reset values and divide ratios.
  assumes nothing of its surroundings.
*/
package baud_gen_pkg;

  // register word indices; the byte address on the bus is four times the index
  localparam logic [7:0] RX_CTRL_ADDR   = 8'h18;
  localparam logic [7:0] TX_CTRL_ADDR   = 8'h98;
  localparam logic [7:0] DIVISOR_ADDR   = 8'h99;
  localparam int         ADDR_IDX_HI    = 9;
  localparam int         ADDR_IDX_LO    = 2;

  // transmit_control_status field positions
  localparam int CLK_SRC_BIT    = 7;
  localparam int MODE_SYNC_BIT  = 4;
  localparam int UNIMPL_BIT     = 3;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int SHIFT_EMPTY_BIT = 1;

  // receive_control_status: port enable bit
  localparam int PORT_EN_BIT    = 7;

  // reset values
  localparam logic [7:0] TX_CTRL_RESET = 8'h02;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;

  // writable masks
  localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;

  // post dividers: async low 64, async high 16, sync 4 (all counts minus one)
  localparam logic [5:0] POST_LOW_MAX  = 6'h3F;
  localparam logic [5:0] POST_HIGH_MAX = 6'h0F;
  localparam logic [5:0] POST_SYNC_MAX = 6'h03;

  // post divider start value
  localparam logic [5:0] ZERO6 = 6'h00;

  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage : baud_gen_pkg

// ==== core/usart_baud_rate_generator.sv ====
/*
  serial port rate generator with ahb-lite register slave and a
  three-sample majority detector on the receive data pin.
  assumes a single clock hclk, the shift logic outside consumes the
  tick outputs and reports its shift register state on shift_empty.
  registers sit on word indices: the byte address is four times the
  index, and a read right behind a write sees the written value.
*/
// Contract
// - one 8-bit rate generator serves asynchronous and synchronous modes.
// - divisor sets the period of a free-running 8-bit timer.
// - high speed select joins the divisor in setting async rate.
// - synchronous mode ignores the high speed select bit.
// - async low speed rate is clock over 64 times divisor plus one.
// - async high speed rate is clock over 16 times divisor plus one.
// - synchronous rate is clock over 4 times divisor plus one.
// - rate output drives bit clock in async mode and sync master mode, sync slave takes external.
// - any divisor write resets the timer at once.
// - receive pin sampled three times, majority decides level.
// - divisor is unsigned 8-bit, 0 through 255, used by all formulas.
// - reset clears the divisor to zero.
// - mode bit set selects synchronous, cleared selects asynchronous.
// - async generated clock runs at 16 or 64 times the bit rate.
// - sync clock source set is master from generator, cleared is slave.
`timescale 1ns/10ps
`default_nettype none

module usart_baud_rate_generator
  import baud_gen_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        receive_data_pin,
  input  wire logic        ext_bit_clk,
  input  wire logic        shift_empty,
  output logic             rate_tick,
  output logic             bit_tick,
  output logic             sample_tick,
  output logic             line_level,
  output logic             sync_mode,
  output logic             clk_master
);

  // register state
  logic [7:0]       tx_ctrl_r;
  logic [7:0]       rx_ctrl_r;
  logic [DIV_W-1:0] divisor_r;

  // address phase capture
  logic             wr_pend_r;
  logic [7:0]       wr_addr_r;

  // timer and post divider
  logic [DIV_W-1:0] timer_r;
  logic [5:0]       post_r;
  logic [5:0]       post_max;
  logic             timer_zero;
  logic             div_wr;
  logic [DIV_W-1:0] tick_gap_r; // cycles since the last tick or write, for checks

  // receive pin synchroniser and majority
  logic             rx_meta_r;
  logic             rx_sync_r;
  logic [2:0]       rx_samp_r;
  logic             ext_meta_r;
  logic             ext_sync_r;
  logic             ext_prev_r;

  // bus decode: a valid transfer is taken when hready is high
  function automatic logic xfer_ok(input logic sel, input logic [1:0] tr, input logic rdy);
    xfer_ok = sel && rdy && tr[1];
  endfunction : xfer_ok

  // register read mux, unmapped reads give zero
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] tx,
                                          input logic [7:0] rx, input logic [7:0] dv);
    if (a == TX_CTRL_ADDR) begin
      reg_read = tx;
    end else if (a == RX_CTRL_ADDR) begin
      reg_read = rx;
    end else if (a == DIVISOR_ADDR) begin
      reg_read = dv;
    end else begin
      reg_read = 8'h00;
    end
  endfunction : reg_read

  // value a write leaves in a register; the shift empty bit comes from its live source, other read-only bits read zero
  function automatic logic [7:0] write_value(input logic [7:0] a, input logic [7:0] d,
                                             input logic se);
    if (a == TX_CTRL_ADDR) begin
      write_value = (d & TX_CTRL_WMASK) | ({7'h00, se} << SHIFT_EMPTY_BIT);
    end else if (a == RX_CTRL_ADDR) begin
      write_value = d & RX_CTRL_WMASK;
    end else if (a == DIVISOR_ADDR) begin
      write_value = d;
    end else begin
      write_value = 8'h00;
    end
  endfunction : write_value

  // slave always ready and okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture for writes, read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= xfer_ok(hsel, htrans, hready) && hwrite;
      wr_addr_r <= haddr[ADDR_IDX_HI:ADDR_IDX_LO]; // registers sit on word indices
    end
  end

  // read data flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (xfer_ok(hsel, htrans, hready) && !hwrite) begin
      if (wr_pend_r && (wr_addr_r == haddr[ADDR_IDX_HI:ADDR_IDX_LO])) begin
        // a write in its data phase lands at this edge, so forward it to the read
        hrdata <= {24'h00_0000, write_value(wr_addr_r, hwdata[7:0], shift_empty)};
      end else begin
        hrdata <= {24'h00_0000, reg_read(haddr[ADDR_IDX_HI:ADDR_IDX_LO], tx_ctrl_r, rx_ctrl_r, divisor_r)};
      end
    end
  end

  assign div_wr = wr_pend_r && (wr_addr_r == DIVISOR_ADDR);

  // divisor register, cleared at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      divisor_r <= DIV_W'(DIVISOR_RESET);
    end else if (div_wr) begin
      divisor_r <= hwdata[DIV_W-1:0];
    end
  end

  // transmit control, shift empty flag follows the shift logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ctrl_r <= TX_CTRL_RESET;
    end else begin
      if (wr_pend_r && (wr_addr_r == TX_CTRL_ADDR)) begin
        tx_ctrl_r <= write_value(TX_CTRL_ADDR, hwdata[7:0], shift_empty);
      end else begin
        tx_ctrl_r[SHIFT_EMPTY_BIT] <= shift_empty;
      end
    end
  end

  // receive control, only the upper control bits stored here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ctrl_r <= RX_CTRL_RESET;
    end else if (wr_pend_r && (wr_addr_r == RX_CTRL_ADDR)) begin
      rx_ctrl_r <= write_value(RX_CTRL_ADDR, hwdata[7:0], 1'b0);
    end
  end

  assign sync_mode  = tx_ctrl_r[MODE_SYNC_BIT];
  assign clk_master = tx_ctrl_r[CLK_SRC_BIT];

  // post divider ratio: high speed only matters in async mode
  always_comb begin
    if (sync_mode) begin
      post_max = POST_SYNC_MAX;
    end else if (tx_ctrl_r[HIGH_SPEED_BIT]) begin
      post_max = POST_HIGH_MAX;
    end else begin
      post_max = POST_LOW_MAX;
    end
  end

  assign timer_zero = (timer_r == '0);

  // free running down counter, reloaded on zero and on any divisor write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_r <= '0;
    end else if (div_wr) begin
      timer_r <= hwdata[DIV_W-1:0];
    end else if (timer_zero) begin
      timer_r <= divisor_r;
    end else begin
      timer_r <= timer_r - 1'b1;
    end
  end

  assign rate_tick = timer_zero && !div_wr;

  // cycles since the last tick or divisor write, watched by the period checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_gap_r <= '0;
    end else if (rate_tick || div_wr) begin
      tick_gap_r <= '0;
    end else begin
      tick_gap_r <= tick_gap_r + 1'b1;
    end
  end

  // post divider: async tick is 16 or 64 rate ticks per bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_r <= ZERO6;
    end else if (div_wr) begin
      post_r <= ZERO6;
    end else if (rate_tick) begin
      if (post_r >= post_max) begin
        post_r <= ZERO6;
      end else begin
        post_r <= post_r + 6'h01;
      end
    end
  end

  // external bit clock synchroniser and edge detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= ext_bit_clk;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  // sample tick is the generator clock, bit tick chooses source
  always_comb begin
    sample_tick = rate_tick;
    if (sync_mode && !clk_master) begin
      bit_tick = ext_sync_r && !ext_prev_r;
    end else begin
      bit_tick = rate_tick && (post_r >= post_max);
    end
  end

  // receive pin synchroniser and three sample shift
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_samp_r <= 3'h7;
    end else begin
      rx_meta_r <= receive_data_pin;
      rx_sync_r <= rx_meta_r;
      if (rate_tick) begin
        rx_samp_r <= {rx_samp_r[1:0], rx_sync_r};
      end
    end
  end

  // majority of three samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_level <= 1'b1;
    end else begin
      line_level <= (rx_samp_r[0] & rx_samp_r[1]) | (rx_samp_r[1] & rx_samp_r[2])
                    | (rx_samp_r[0] & rx_samp_r[2]);
    end
  end

  // divisor reads zero on the first cycle after reset is released
  div_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> divisor_r == '0) else $error("divisor not zero after reset");

  // timer reloads with the written value on the cycle after a write
  div_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    div_wr |=> timer_r == $past(hwdata[DIV_W-1:0])) else $error("write did not restart timer");

  // timer period equals divisor plus one, three cycles, checked only at divisor 2
  tick_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rate_tick && divisor_r == 8'h02 && !div_wr) ##1 (!div_wr)[*3] |-> $past(rate_tick, 3) == 1'b1 && rate_tick)
    else $error("timer period wrong");

  // timer counts down by one when not zero
  count_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!timer_zero && !div_wr) |=> timer_r == $past(timer_r) - 1'b1) else $error("timer did not count down");

  // sync mode ignores high speed bit
  sync_ratio_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sync_mode |-> post_max == POST_SYNC_MAX) else $error("sync ratio wrong");

  // async high speed gives divide by 16
  async_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!sync_mode && tx_ctrl_r[HIGH_SPEED_BIT]) |-> post_max == POST_HIGH_MAX) else $error("high ratio wrong");

  // async low speed gives divide by 64
  async_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!sync_mode && !tx_ctrl_r[HIGH_SPEED_BIT]) |-> post_max == POST_LOW_MAX) else $error("low ratio wrong");

  // slave mode bit clock never comes from the generator alone
  slave_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sync_mode && !clk_master && bit_tick) |-> $rose(ext_sync_r)) else $error("slave tick not external");

  // majority of three stable lows reads low on the next cycle
  majority_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_samp_r == 3'h0) |=> !line_level) else $error("majority low missed");

  // majority of three stable highs reads high on the next cycle
  majority_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_samp_r == 3'h7) |=> line_level) else $error("majority high missed");

  // each tick comes exactly divisor plus one cycles after the last tick or write
  tick_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rate_tick |-> tick_gap_r == divisor_r) else $error("tick spacing wrong");

  // no tick is skipped once the gap reaches the divisor
  tick_late_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rate_tick && !div_wr) |-> tick_gap_r < divisor_r) else $error("tick came late");

  // terminal count reloads the stored divisor
  count_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_zero && !div_wr) |=> timer_r == $past(divisor_r)) else $error("timer did not reload");

  // a divisor write lands in the register
  write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    div_wr |=> divisor_r == $past(hwdata[DIV_W-1:0])) else $error("divisor write lost");

  // a divisor write also restarts the post divider
  restart_post_a: assert property (@(posedge hclk) disable iff (!hresetn)
    div_wr |=> post_r == ZERO6) else $error("post divider not restarted");

  // with the generator as source every bit tick falls on a rate tick
  bit_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!(sync_mode && !clk_master) && bit_tick) |-> rate_tick) else $error("bit tick off the rate clock");

  // the sampling clock is the generator clock itself
  sample_same_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_tick == rate_tick) else $error("sample tick not the rate clock");

endmodule : usart_baud_rate_generator

`default_nettype wire

// ==== core/dummy_unused.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== verif/shift_partner.sv ====
/*
  far side model of the shift logic: slave bit clock and shift state.
  assumes the hclk domain and a bench that commands busy and clk_en.
*/
`timescale 1ns/10ps
`default_nettype none
module shift_partner #(
  parameter int HALF = 10
) (
  input  wire logic hclk,
  input  wire logic clk_en,
  input  wire logic busy,
  output var  logic ext_bit_clk,
  output logic      shift_empty
);
  int cnt;
  // slave bit clock, held low outside frames
  always @(posedge hclk) begin
    if (!clk_en) begin
      cnt <= 0;
      ext_bit_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_bit_clk <= ~ext_bit_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // shift register state seen by the port
  assign shift_empty = ~busy;
endmodule : shift_partner
`default_nettype wire

// ==== verif/tb_usart_baud_rate_generator.sv ====
/*
  self-checking bench for the rate generator: ahb-lite master, queue of
  expected values, monitor measuring tick periods and line level.
  assumes shift_partner and the design package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CMP(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_usart_baud_rate_generator;
  import baud_gen_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_pin;
  logic        clk_en, busy, ext_clk, shift_empty, rate_tick, bit_tick;
  logic        sample_tick, line_level, sync_mode, clk_master;
  logic [31:0] haddr, hwdata, hrdata, got, exp_v;
  logic [1:0]  htrans, msel, obs;
  logic [2:0]  hsize;
  logic [31:0] exp_q[$];
  logic [7:0]  mode_tx[4] = '{8'h00, 8'h04, 8'h90, 8'h94};
  int          mult[4] = '{64, 16, 4, 4};
  int          fails, n_checks, gap, seen, n;

  assign hready = hreadyout;
  usart_baud_rate_generator dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .receive_data_pin(rx_pin),
    .ext_bit_clk(ext_clk), .shift_empty(shift_empty), .rate_tick(rate_tick),
    .bit_tick(bit_tick), .sample_tick(sample_tick), .line_level(line_level),
    .sync_mode(sync_mode), .clk_master(clk_master));
  shift_partner far_u (.hclk(hclk), .clk_en(clk_en), .busy(busy), .ext_bit_clk(ext_clk),
    .shift_empty(shift_empty));

  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic give_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin fails++; give_verdict(); end
  endtask : wait_rdy

  // single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {22'h0, a, 2'b00}; hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= w;
    wait_rdy();
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d; obs <= w ? 2'h0 : 2'h1;
    wait_rdy();
    obs <= 2'h0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic look(input logic [1:0] c, input logic [31:0] e, input int k);
    repeat (k) exp_q.push_back(e);
    @(posedge hclk);
    obs <= c;
    repeat (k) @(posedge hclk);
    obs <= 2'h0;
  endtask : look

  // period of the selected tick between its first two pulses
  task automatic meas(input logic [1:0] s, input int e);
    int k;
    exp_q.push_back(32'(e));
    msel <= s;
    k = 0;
    do begin @(posedge hclk); k++; end while (seen < 2 && k < 3 * e + 40);
    msel <= 2'h0;
    if (seen < 2) begin fails++; give_verdict(); end
    @(posedge hclk);
  endtask : meas

  // monitor: compares the oldest note with each result that appears
  always @(posedge hclk) begin
    if (obs != 2'h0 && hready === 1'b1 && exp_q.size() > 0) begin
      got = obs == 2'h1 ? hrdata : obs == 2'h2 ? {31'h0, line_level} : {30'h0, clk_master, sync_mode};
      exp_v = exp_q.pop_front();
      `CMP(got, exp_v)
      `CMP(hresp, 1'b0)
    end
    if (msel == 2'h0) begin
      seen <= 0;
      gap  <= 0;
    end else if ((msel == 2'h1 ? rate_tick : bit_tick) === 1'b1) begin
      if (seen == 1 && exp_q.size() > 0) begin
        exp_v = exp_q.pop_front();
        `CMP(32'(gap + 1), exp_v)
      end
      if (msel == 2'h1) `CMP(sample_tick, rate_tick)
      seen <= seen + 1;
      gap  <= 0;
    end else begin
      gap <= gap + 1;
    end
  end

  // main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = HSIZE_WORD;
    hwdata = 32'h0; rx_pin = 1'b1; clk_en = 1'b0; busy = 1'b0; msel = 2'h0; obs = 2'h0;
    fails = 0; n_checks = 0;
    void'($urandom(89));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(TX_CTRL_ADDR, 32'h02);
    rd(RX_CTRL_ADDR, 32'h00);
    rd(DIVISOR_ADDR, 32'h00);
    bus(1'b1, TX_CTRL_ADDR, 32'hFF);
    rd(TX_CTRL_ADDR, 32'hF7);
    look(2'h3, 32'h3, 1);
    busy <= 1'b1;
    @(posedge hclk);
    rd(TX_CTRL_ADDR, 32'hF5);
    busy <= 1'b0;
    bus(1'b1, RX_CTRL_ADDR, 32'hFF);
    rd(RX_CTRL_ADDR, 32'hF8);
    bus(1'b1, 8'h40, 32'hFF);
    rd(8'h40, 32'h00);
    bus(1'b1, TX_CTRL_ADDR, 32'h00);
    for (int i = 0; i < 4; i++) begin
      n = $urandom_range(7, 0);
      bus(1'b1, DIVISOR_ADDR, 32'(n));
      rd(DIVISOR_ADDR, 32'(n));
      meas(2'h1, n + 1);
    end
    bus(1'b1, DIVISOR_ADDR, 32'hFF);
    meas(2'h1, 256);
    repeat (10) @(posedge hclk);
    bus(1'b1, DIVISOR_ADDR, 32'h03);
    meas(2'h1, 4);
    bus(1'b1, DIVISOR_ADDR, 32'h02);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, TX_CTRL_ADDR, 32'(mode_tx[i]));
      meas(2'h2, 3 * mult[i]);
    end
    bus(1'b1, TX_CTRL_ADDR, 32'h10);
    look(2'h3, 32'h1, 1);
    clk_en <= 1'b1;
    meas(2'h2, 20);
    clk_en <= 1'b0;
    bus(1'b1, DIVISOR_ADDR, 32'h00);
    rx_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    look(2'h2, 32'h0, 2);
    rx_pin <= 1'b1;
    @(posedge hclk);
    rx_pin <= 1'b0;
    look(2'h2, 32'h0, 8);
    rx_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    look(2'h2, 32'h1, 2);
    bus(1'b1, DIVISOR_ADDR, 32'h5A);
    rd(DIVISOR_ADDR, 32'h5A);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(DIVISOR_ADDR, 32'h00);
    rd(TX_CTRL_ADDR, 32'h02);
    give_verdict();
  end
endmodule : tb_usart_baud_rate_generator
`default_nettype wire
